/* File: design/chan_reg_bank.sv */
// one channel's control, status, channel status and reserved registers
// assumes single-cycle write and read strobes from the frame logic
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_cfg.svh"
module chan_reg_bank #(
  parameter logic [1:0] CHAN = 2'h0,
  parameter int SC_HOLD = `SC_HOLD_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic strap_load,
  input wire logic [2:0] straps,
  input wire phy_mgmt_pkg::chan_stat_s stat,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [4:0] addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic [15:0] ctrl
);
  import phy_mgmt_pkg::*;
  localparam logic [7:0] SC_W = 8'(SC_HOLD);
  localparam logic [15:0] RSV_DFLT [4] = '{`RSV16_DEFAULT, `RSV17_DEFAULT,
    `RSV19_DEFAULT, `RSV20_DEFAULT};
  logic [2:0] strap_q;
  logic [2:0] next_strap_q;
  logic [15:0] next_ctrl;
  logic [15:0] rsv [4];
  logic [15:0] next_rsv [4];
  logic [7:0] sc_cnt;
  logic [7:0] next_sc;
  logic far_q;
  logic jab_q;
  logic lost_q;
  logic next_far;
  logic next_jab;
  logic next_lost;
  logic [15:0] dflt;
  logic [15:0] stat_word;
  logic [15:0] cso_word;
  logic rsv_hit;
  logic [1:0] rsv_idx;
  logic rd_clr;
  logic reset_done;

  if (SC_HOLD < 2 || SC_HOLD > 255)
  begin : g_bad_hold
    $error("self-clear hold count out of range");
  end

  always_comb
  begin
    rsv_hit = 1'b1;
    rsv_idx = 2'h0;
    unique case (addr)
      `REG_RSV16: rsv_idx = 2'h0;
      `REG_RSV17: rsv_idx = 2'h1;
      `REG_RSV19: rsv_idx = 2'h2;
      `REG_RSV20: rsv_idx = 2'h3;
      default: rsv_hit = 1'b0;
    endcase
    dflt = `CTRL_DEFAULT;
    dflt[`CTRL_SPEED] = strap_q[2];
    dflt[`CTRL_ANEG] = strap_q[1];
    dflt[`CTRL_DUPLEX_SELECT_BIT] = strap_q[0];
    rd_clr = rd_en && addr == `REG_STAT;
    reset_done = sc_cnt == 8'h01 && ctrl[`CTRL_RESET];
  end

  // straps seen once after each reset release stand in for the defaults
  always_comb
  begin
    next_strap_q = strap_load ? straps : strap_q;
    next_ctrl = ctrl;
    next_rsv = rsv;
    next_sc = sc_cnt;
    if (sc_cnt != 8'h00)
      next_sc = sc_cnt - 8'h01;
    if (reset_done)
    begin
      next_ctrl = dflt;
      next_rsv = RSV_DFLT;
    end
    else if (sc_cnt == 8'h01)
      next_ctrl = ctrl & ~`CTRL_SC_MASK;
    if (strap_load)
    begin
      next_ctrl[`CTRL_SPEED] = straps[2];
      next_ctrl[`CTRL_ANEG] = straps[1];
      next_ctrl[`CTRL_DUPLEX_SELECT_BIT] = straps[0];
    end
    if (wr_en && addr == `REG_CTRL)
    begin
      next_ctrl = wr_data & `CTRL_WR_MASK;
      // hold timer for self clearing bits
      if ((wr_data & `CTRL_SC_MASK) != 16'h0000)
        next_sc = SC_W;
    end
    if (wr_en && rsv_hit)
      next_rsv[rsv_idx] = wr_data;
  end

  // a new event beats the read clear
  always_comb
  begin
    next_far = stat.far_fault | (far_q & ~rd_clr);
    next_jab = stat.jabber | (jab_q & ~rd_clr);
    next_lost = stat.link_fail | (lost_q & ~rd_clr);
    if (reset_done)
    begin
      next_far = stat.far_fault;
      next_jab = stat.jabber;
      next_lost = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_q <= 3'h6;
      ctrl <= `CTRL_DEFAULT;
      rsv <= RSV_DFLT;
      sc_cnt <= 8'h00;
      far_q <= 1'b0;
      jab_q <= 1'b0;
      lost_q <= 1'b1;
    end
    else
    begin
      strap_q <= next_strap_q;
      ctrl <= next_ctrl;
      rsv <= next_rsv;
      sc_cnt <= next_sc;
      far_q <= next_far;
      jab_q <= next_jab;
      lost_q <= next_lost;
    end
  end

  always_comb
  begin
    stat_word = `STAT_FIXED;
    stat_word[`STAT_AN_DONE] = stat.an_done;
    stat_word[`STAT_FAR_FAULT] = far_q;
    stat_word[`STAT_LINK] = ~lost_q;
    stat_word[`STAT_JAB] = jab_q;
    cso_word = {stat.rev_pol, stat.desync_to, 4'h0, CHAN, 1'b0, stat.link_fail,
      stat.spd_det, stat.duplex_select_bit_det, stat.code_err, stat.ssd_err, stat.esd_err,
      stat.jabber};
    rd_data = 16'h0000;
    if (rsv_hit)
      rd_data = rsv[rsv_idx];
    else if (addr == `REG_CTRL)
      rd_data = ctrl;
    else if (addr == `REG_STAT)
      rd_data = stat_word;
    else if (addr == `REG_CSO)
      rd_data = cso_word;
  end

  AST_RESET_DONE: assert property (@(posedge core_clk) disable iff (!nrst)
    reset_done && !wr_en && !strap_load |=> ctrl == $past(dflt))
    else $error("channel reset did not restore defaults");
  AST_SC_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
    sc_cnt == 8'h01 && !wr_en |=> !ctrl[9] && !ctrl[7] && !ctrl[15])
    else $error("self clearing bit stuck");
  AST_COLTEST_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_en && addr == `REG_CTRL && wr_data[7] |=> sc_cnt == SC_W && ctrl[7])
    else $error("collision test bit not armed");
  AST_FAR_LATCH: assert property (@(posedge core_clk) disable iff (!nrst)
    stat.far_fault |=> stat_word[`STAT_FAR_FAULT])
    else $error("far fault not latched");
  AST_LINK_LOW: assert property (@(posedge core_clk) disable iff (!nrst)
    stat.link_fail |=> !stat_word[`STAT_LINK] ##1 (!stat_word[`STAT_LINK] || $past(rd_clr)))
    else $error("link loss not latched");
  AST_JAB_HOLD: assert property (@(posedge core_clk) disable iff (!nrst)
    jab_q && !rd_clr && !reset_done |=> stat_word[`STAT_JAB])
    else $error("jabber latch lost without read");
  AST_FIXED_BITS: assert property (@(posedge core_clk) disable iff (!nrst)
    (stat_word & 16'hffc9) == `STAT_FIXED)
    else $error("fixed status bits wrong");
  AST_CHAN_FIELD: assert property (@(posedge core_clk) disable iff (!nrst)
    cso_word[9:8] == CHAN)
    else $error("channel number field wrong");
  AST_STRAP: assert property (@(posedge core_clk) disable iff (!nrst)
    strap_load && !wr_en |=> ctrl[`CTRL_SPEED] == $past(straps[2]))
    else $error("speed strap not applied");
endmodule : chan_reg_bank
`default_nettype wire

/* File: design/mgmt_pin_sampler.sv */
// synchronises the link clock, link data and strap pins, finds link clock rises
// assumes link data holds at least two core cycles past each link clock rise
`timescale 1ns/1ps
`default_nettype none
module mgmt_pin_sampler (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic [5:0] strap_in,
  mgmt_sample_if.src smp
);
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic clk_prev;
  logic [7:0] next_sync1;
  logic [7:0] next_sync2;
  logic next_clk_prev;

  always_comb
  begin
    next_sync1 = {mdc, mdio_in, strap_in};
    next_sync2 = sync1;
    next_clk_prev = sync2[7];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
      clk_prev <= 1'b0;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      clk_prev <= next_clk_prev;
    end
  end

  assign smp.rise = sync2[7] & ~clk_prev;
  assign smp.bit_val = sync2[6];
  assign smp.straps = sync2[5:0];
endmodule : mgmt_pin_sampler
`default_nettype wire

/* File: design/mgmt_sample_if.sv */
// carries sampled link events from the pin sampler to the frame logic
// assumes both ends run on core_clk
`timescale 1ns/1ps
`default_nettype none
interface mgmt_sample_if;
  logic rise;
  logic bit_val;
  logic [5:0] straps;
  modport src (output rise, output bit_val, output straps);
  modport dst (input rise, input bit_val, input straps);
endinterface : mgmt_sample_if
`default_nettype wire

/* File: design/phy_mgmt_cfg.svh */
// offsets, field positions, reset values and counts of the channel management registers
// assumes every user includes it by bare name; definitions only
`ifndef PHY_MGMT_CFG_SVH
`define PHY_MGMT_CFG_SVH
`define REG_CTRL 5'h00
`define REG_STAT 5'h01
`define REG_RSV16 5'h10
`define REG_RSV17 5'h11
`define REG_CSO 5'h12
`define REG_RSV19 5'h13
`define REG_RSV20 5'h14
`define CTRL_RESET 15
`define CTRL_SPEED 13
`define CTRL_ANEG 12
`define CTRL_DUPLEX_SELECT_BIT 8
`define CTRL_DEFAULT 16'h3400
`define CTRL_WR_MASK 16'hff80
`define CTRL_SC_MASK 16'h8280
`define STAT_FIXED 16'h7809
`define STAT_AN_DONE 5
`define STAT_FAR_FAULT 4
`define STAT_LINK 2
`define STAT_JAB 1
`define RSV16_DEFAULT 16'h0048
`define RSV17_DEFAULT 16'h0002
`define RSV19_DEFAULT 16'h007f
`define RSV20_DEFAULT 16'h0000
`define PREAMBLE_ONES 6'h20
`define OP_READ 2'h2
`define OP_WRITE 2'h1
`define HDR_LAST 4'hb
`define DATA_LAST 4'hf
`define SC_HOLD_CYCLES 16
`define STRAP_LOAD_AT 2'h2
`endif

/* File: design/phy_mgmt_pkg.sv */
// types shared by the management register bank modules
// assumes nothing beyond the cfg header
package phy_mgmt_pkg;
  typedef struct packed {
    logic rev_pol;
    logic desync_to;
    logic link_fail;
    logic spd_det;
    logic duplex_select_bit_det;
    logic code_err;
    logic ssd_err;
    logic esd_err;
    logic jabber;
    logic an_done;
    logic far_fault;
  } chan_stat_s;
  typedef enum logic [2:0] {
    st_preamble,
    st_start,
    st_header,
    st_turn,
    st_read,
    st_write
  } mgmt_state_e;
endpackage : phy_mgmt_pkg

/* File: design/phy_mgmt_top.sv */
// management frame engine and four channel register banks
// assumes the link clock and data arrive unsynchronised; channel status is on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_cfg.svh"
module phy_mgmt_top #(
  parameter int SC_HOLD = `SC_HOLD_CYCLES
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic [2:0] device_address_field,
  input wire logic speed_strap,
  input wire logic aneg_strap,
  input wire logic duplex_strap,
  input wire phy_mgmt_pkg::chan_stat_s [3:0] chan_stat,
  output logic [3:0][15:0] chan_ctrl
);
  import phy_mgmt_pkg::*;
  mgmt_sample_if smp ();
  mgmt_state_e state;
  mgmt_state_e next_state;
  logic [5:0] ones_cnt;
  logic [5:0] next_ones;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [15:0] shreg;
  logic [15:0] next_shreg;
  logic op_read;
  logic next_op_read;
  logic [1:0] chan_sel;
  logic [1:0] next_chan_sel;
  logic [4:0] reg_sel;
  logic [4:0] next_reg_sel;
  logic next_mdio_out;
  logic next_mdio_oe_n;
  logic wr_go;
  logic next_wr_go;
  logic rd_pulse;
  logic [11:0] hdr;
  logic [1:0] strap_cnt;
  logic [1:0] next_strap_cnt;
  logic strap_load;
  logic [15:0] rd_word [4];
  logic [15:0] rd_sel;

  mgmt_pin_sampler u_sampler (
    .core_clk(core_clk),
    .nrst(nrst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .strap_in({device_address_field, speed_strap, aneg_strap, duplex_strap}),
    .smp(smp.src)
  );

  // synchronised straps settle two edges after release; load them on the third
  always_comb
  begin
    next_strap_cnt = strap_cnt;
    if (strap_cnt != 2'h3)
      next_strap_cnt = strap_cnt + 2'h1;
    strap_load = strap_cnt == `STRAP_LOAD_AT;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      strap_cnt <= 2'h0;
    else
      strap_cnt <= next_strap_cnt;
  end

  // low address bits pick the bank
  for (genvar i = 0; i < 4; i++)
  begin : g_chan
    chan_reg_bank #(
      .CHAN(2'(i)),
      .SC_HOLD(SC_HOLD)
    ) u_bank (
      .core_clk(core_clk),
      .nrst(nrst),
      .strap_load(strap_load),
      .straps(smp.straps[2:0]),
      .stat(chan_stat[i]),
      .wr_en(wr_go && chan_sel == 2'(i)),
      .rd_en(rd_pulse && chan_sel == 2'(i)),
      .addr(reg_sel),
      .wr_data(shreg),
      .rd_data(rd_word[i]),
      .ctrl(chan_ctrl[i])
    );
  end

  assign rd_sel = rd_word[chan_sel];
  assign hdr = {shreg[10:0], smp.bit_val};

  always_comb
  begin
    next_state = state;
    next_ones = ones_cnt;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_op_read = op_read;
    next_chan_sel = chan_sel;
    next_reg_sel = reg_sel;
    next_mdio_out = mdio_out;
    next_mdio_oe_n = mdio_oe_n;
    next_wr_go = 1'b0;
    rd_pulse = 1'b0;
    if (smp.rise)
    begin
      unique case (state)
        st_preamble:
        begin
          if (smp.bit_val)
          begin
            if (ones_cnt != `PREAMBLE_ONES)
              next_ones = ones_cnt + 6'h01;
          end
          // a zero before 32 ones restarts the count
          else if (ones_cnt == `PREAMBLE_ONES)
            next_state = st_start;
          else
            next_ones = 6'h00;
        end
        st_start:
        begin
          next_ones = 6'h00;
          next_bit_cnt = 4'h0;
          next_state = smp.bit_val ? st_header : st_preamble;
        end
        st_header:
        begin
          next_shreg = {shreg[14:0], smp.bit_val};
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == `HDR_LAST)
          begin
            next_bit_cnt = 4'h0;
            next_op_read = hdr[11:10] == `OP_READ;
            next_chan_sel = hdr[6:5];
            next_reg_sel = hdr[4:0];
            if (hdr[9:7] == smp.straps[5:3] &&
                (hdr[11:10] == `OP_READ || hdr[11:10] == `OP_WRITE))
              next_state = st_turn;
            else
              next_state = st_preamble;
          end
        end
        st_turn:
        begin
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == 4'h0 && op_read)
          begin
            next_mdio_oe_n = 1'b0;
            next_mdio_out = 1'b0;
          end
          else if (bit_cnt != 4'h0)
          begin
            next_bit_cnt = 4'h0;
            if (op_read)
            begin
              // snapshot and clear-on-read in the same edge
              rd_pulse = 1'b1;
              next_shreg = rd_sel;
              next_mdio_out = rd_sel[15];
              next_state = st_read;
            end
            else
              next_state = st_write;
          end
        end
        st_read:
        begin
          next_bit_cnt = bit_cnt + 4'h1;
          next_shreg = {shreg[14:0], 1'b0};
          next_mdio_out = shreg[14];
          if (bit_cnt == `DATA_LAST)
          begin
            next_mdio_oe_n = 1'b1;
            next_mdio_out = 1'b0;
            next_state = st_preamble;
          end
        end
        st_write:
        begin
          next_bit_cnt = bit_cnt + 4'h1;
          next_shreg = {shreg[14:0], smp.bit_val};
          if (bit_cnt == `DATA_LAST)
          begin
            next_wr_go = 1'b1;
            next_state = st_preamble;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= st_preamble;
      ones_cnt <= 6'h00;
      bit_cnt <= 4'h0;
      shreg <= 16'h0000;
      op_read <= 1'b0;
      chan_sel <= 2'h0;
      reg_sel <= 5'h00;
      mdio_out <= 1'b0;
      mdio_oe_n <= 1'b1;
      wr_go <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ones_cnt <= next_ones;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      op_read <= next_op_read;
      chan_sel <= next_chan_sel;
      reg_sel <= next_reg_sel;
      mdio_out <= next_mdio_out;
      mdio_oe_n <= next_mdio_oe_n;
      wr_go <= next_wr_go;
    end
  end

  sequence s_header_end;
    smp.rise && state == st_header && bit_cnt == `HDR_LAST;
  endsequence
  sequence s_read_rise;
    smp.rise && state == st_read && bit_cnt != `DATA_LAST;
  endsequence
  sequence s_read_last;
    smp.rise && state == st_read && bit_cnt == `DATA_LAST;
  endsequence
  sequence s_write_last;
    smp.rise && state == st_write && bit_cnt == `DATA_LAST;
  endsequence

  property p_msb_first;
    @(posedge core_clk) disable iff (!nrst)
    s_read_rise |=> mdio_out == $past(shreg[14]) && !mdio_oe_n;
  endproperty
  property p_addr_miss;
    @(posedge core_clk) disable iff (!nrst)
    s_header_end and (hdr[9:7] != smp.straps[5:3]) |=> state == st_preamble;
  endproperty
  property p_release;
    @(posedge core_clk) disable iff (!nrst)
    s_read_last |=> mdio_oe_n && state == st_preamble;
  endproperty
  property p_write_go;
    @(posedge core_clk) disable iff (!nrst)
    s_write_last |=> wr_go ##1 !wr_go;
  endproperty

  AST_PREAMBLE_COUNT: assert property (@(posedge core_clk) disable iff (!nrst)
    state == st_preamble && next_state == st_start |-> ones_cnt == `PREAMBLE_ONES)
    else $error("frame started before 32 preamble ones");
  AST_NEED_PREAMBLE: assert property (@(posedge core_clk) disable iff (!nrst)
    state == st_start |-> $past(state) == st_start || $past(ones_cnt) == `PREAMBLE_ONES)
    else $error("start accepted without preamble");
  AST_MSB_FIRST: assert property (p_msb_first)
    else $error("read data not shifted msb first");
  AST_ADDR_MISS: assert property (p_addr_miss)
    else $error("frame for another address accepted");
  AST_READ_RELEASE: assert property (p_release)
    else $error("link data not released after bit 0");
  AST_WRITE_GO: assert property (p_write_go)
    else $error("write strobe not a single pulse");
  AST_DRIVE_ONLY_READ: assert property (@(posedge core_clk) disable iff (!nrst)
    !mdio_oe_n |-> op_read && (state == st_turn || state == st_read))
    else $error("link data driven outside a read");
endmodule : phy_mgmt_top
`default_nettype wire

/* File: testbench/mgmt_station_model.sv */
// station management controller: clocks frames onto the serial link
// assumes the bench resolves the shared data wire (pull-up) and feeds it back on mdio_wire
`timescale 1ns/1ps
`default_nettype none
module mgmt_station_model (
  input wire logic core_clk,
  input wire logic mdio_wire,
  output logic mdc,
  output logic m_out,
  output logic m_oe
);
  // link clock stands low between frames
  initial
  begin
    mdc = 1'b0;
    m_out = 1'b0;
    m_oe = 1'b0;
  end

  // 80 ns low with data set up, 80 ns high; data held well past the rise
  task automatic link_bit(input logic drv, input logic v, output logic smp);
    m_oe = drv;
    m_out = v;
    repeat (8) @(negedge core_clk);
    smp = mdio_wire;
    mdc = 1'b1;
    repeat (8) @(negedge core_clk);
    mdc = 1'b0;
  endtask : link_bit

  task automatic frame(input int ones, input logic [1:0] op, input logic [4:0] adr,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd, output logic ta);
    logic [13:0] hdr;
    logic s;
    logic wr;
    hdr = {2'b01, op, adr, ra};
    wr = (op == 2'b01);
    @(negedge core_clk);
    for (int i = 0; i < ones; i++) link_bit(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) link_bit(1'b1, hdr[i], s);
    link_bit(wr, 1'b1, s);
    link_bit(wr, 1'b0, ta);
    for (int i = 15; i >= 0; i--) link_bit(wr, wd[i], rd[i]);
    m_oe = 1'b0;
  endtask : frame
endmodule : mgmt_station_model
`default_nettype wire

/* File: testbench/phy_channel_mgmt_registers_tb.sv */
// self-checking bench for the channel management register bank
// assumes the station model in its own file and the design package compiled first
`timescale 1ns/1ps
`default_nettype none
module phy_channel_mgmt_registers_tb;
  import phy_mgmt_pkg::*;
  // self-clear hold set longer than the 16-cycle default
  localparam int HOLD = 40;
  logic core_clk, nrst, mdc, mdio_in, mdio_out, mdio_oe_n, m_out, m_oe, tav;
  logic speed_strap, aneg_strap, duplex_strap;
  logic [2:0] dev_addr;
  chan_stat_s [3:0] chan_stat;
  logic [3:0][15:0] chan_ctrl;
  logic [15:0] rdv;
  logic [4:0] rsv_addr [4];
  logic [15:0] rsv_def [4];
  int failures, compares;

  // pulled up when nobody drives
  assign mdio_in = !mdio_oe_n ? mdio_out : (m_oe ? m_out : 1'b1);

  phy_mgmt_top #(.SC_HOLD(HOLD)) i_dut (
    .core_clk(core_clk), .nrst(nrst), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .device_address_field(dev_addr),
    .speed_strap(speed_strap), .aneg_strap(aneg_strap), .duplex_strap(duplex_strap),
    .chan_stat(chan_stat), .chan_ctrl(chan_ctrl));

  mgmt_station_model i_station (
    .core_clk(core_clk), .mdio_wire(mdio_in), .mdc(mdc), .m_out(m_out), .m_oe(m_oe));

  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [1:0] ch, input logic [4:0] ra, input logic [15:0] d);
    i_station.frame(32, 2'b01, {dev_addr, ch}, ra, d, rdv, tav);
  endtask : wr

  task automatic rdc(input logic [1:0] ch, input logic [4:0] ra, input logic [15:0] exp);
    i_station.frame(32, 2'b10, {dev_addr, ch}, ra, 16'h0000, rdv, tav);
    check(rdv, exp);
  endtask : rdc

  task automatic do_reset(input logic s, input logic a, input logic d);
    nrst = 1'b0;
    speed_strap = s;
    aneg_strap = a;
    duplex_strap = d;
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask : do_reset

  task automatic summarize();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    #800us;
    failures++;
    $display("ERROR at %0t: watchdog expired", $time);
    summarize();
  end

  initial
  begin
    failures = 0;
    compares = 0;
    dev_addr = 3'h5;
    chan_stat = {4{11'h100}};
    rsv_addr = '{5'h10, 5'h11, 5'h13, 5'h14};
    rsv_def = '{16'h0048, 16'h0002, 16'h007f, 16'h0000};
    do_reset(1'b1, 1'b1, 1'b0);
    for (int c = 0; c < 4; c++) check(chan_ctrl[c], 16'h3400);
    rdc(2'h0, 5'h00, 16'h3400);
    for (int c = 0; c < 4; c++) rdc(c[1:0], 5'h12, {6'h00, c[1:0], 8'h40});
    for (int i = 0; i < 4; i++)
    begin
      rdc(2'h0, rsv_addr[i], rsv_def[i]);
      wr(2'h0, rsv_addr[i], ~rsv_def[i]);
      rdc(2'h0, rsv_addr[i], ~rsv_def[i]);
    end
    rdc(2'h0, 5'h1f, 16'h0000);
    $display("test reset values done");

    wr(2'h3, 5'h00, 16'h5d7f);
    check(chan_ctrl[3], 16'h5d00);
    rdc(2'h3, 5'h00, 16'h5d00);
    wr(2'h3, 5'h00, 16'h0000);
    check(chan_ctrl[3], 16'h0000);
    $display("test control fields done");

    wr(2'h2, 5'h00, 16'h3680);
    check(chan_ctrl[2], 16'h3680);
    repeat (HOLD + 10) @(negedge core_clk);
    check(chan_ctrl[2], 16'h3400);
    wr(2'h2, 5'h10, 16'h1234);
    wr(2'h2, 5'h00, 16'hd900);
    check({15'h0000, chan_ctrl[2][15]}, 16'h0001);
    repeat (HOLD + 10) @(negedge core_clk);
    check(chan_ctrl[2], 16'h3400);
    rdc(2'h2, 5'h10, 16'h0048);
    wr(2'h2, 5'h01, 16'h0000);
    rdc(2'h2, 5'h01, 16'h7809);
    $display("test self clearing done");

    chan_stat[1] = 11'h007;
    repeat (3) @(negedge core_clk);
    chan_stat[1] = 11'h002;
    rdc(2'h1, 5'h01, 16'h783b);
    check({15'h0000, tav}, 16'h0000);
    check({15'h0000, mdio_oe_n}, 16'h0001);
    chan_stat[1] = 11'h000;
    rdc(2'h1, 5'h01, 16'h780d);
    chan_stat[1] = 11'h100;
    repeat (3) @(negedge core_clk);
    chan_stat[1] = 11'h000;
    rdc(2'h1, 5'h01, 16'h7809);
    rdc(2'h1, 5'h01, 16'h780d);
    chan_stat[0] = 11'h6ff;
    rdc(2'h0, 5'h12, 16'hc03f);
    $display("test latched status done");

    i_station.frame(31, 2'b01, {dev_addr, 2'h3}, 5'h00, 16'h1100, rdv, tav);
    check(chan_ctrl[3], 16'h0000);
    i_station.frame(32, 2'b01, {3'h2, 2'h3}, 5'h00, 16'h1100, rdv, tav);
    check(chan_ctrl[3], 16'h0000);
    wr(2'h3, 5'h00, 16'h1100);
    check(chan_ctrl[3], 16'h1100);
    $display("test refused frames done");

    do_reset(1'b0, 1'b0, 1'b1);
    for (int c = 0; c < 4; c++) check(chan_ctrl[c], 16'h0500);
    rdc(2'h1, 5'h00, 16'h0500);
    $display("test strap override done");
    summarize();
  end
endmodule : phy_channel_mgmt_registers_tb
`default_nettype wire
